/* File: sim/pdm_link_properties.sv */
// Checker watching the link between the channel and its peripheral
`timescale 1ns/1ps
module pdm_link_properties (
  input wire logic        clock_in,
  input wire logic        srst_in,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [8:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic        rx_channel_trigger,
  input wire logic        rx_ack,
  input wire logic        tx_channel_trigger,
  input wire logic        tx_wr,
  input wire logic        half_duplex,
  input wire logic        rx_end_flag,
  input wire logic        tx_end_flag,
  input wire logic        rx_buffer_full_flag,
  input wire logic        tx_buffer_empty_flag
);
  // ==========================================================================
  // Shared clocking; flags are only judged outside reset
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Nonzero count write on the link; half duplex aliases rx onto tx
  sequence s_nz_wr(logic [8:0] a);
    reg_wr && !half_duplex && reg_addr == a && reg_wdata[15:0] != 16'h0000;
  endsequence
  property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
  property p_rvalid_cause; reg_rvalid |-> $past(reg_rd); endproperty
  property p_rx_take; rx_ack |-> $past(rx_channel_trigger); endproperty
  property p_tx_take; tx_wr |-> $past(tx_channel_trigger); endproperty
  property p_tx_pulse; tx_wr |=> !tx_wr; endproperty
  property p_rx_end_clr;
    s_nz_wr(pdm_pkg::OFS_RX_CNT) |-> ##[1:2] !rx_end_flag;
  endproperty
  property p_rx_full_clr;
    s_nz_wr(pdm_pkg::OFS_RX_NCNT) |-> ##[1:2] !rx_buffer_full_flag;
  endproperty
  property p_tx_end_clr;
    s_nz_wr(pdm_pkg::OFS_TX_CNT) |-> ##[1:2] !tx_end_flag;
  endproperty
  property p_tx_empty_clr;
    s_nz_wr(pdm_pkg::OFS_TX_NCNT) |-> ##[1:2] !tx_buffer_empty_flag;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("link read not answered next cycle");
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("link read answer without request");
  a_rx_take: assert property (p_rx_take)
    else $error("receive item taken without trigger");
  a_tx_take: assert property (p_tx_take)
    else $error("holding write without transmit trigger");
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("holding write longer than one cycle");
  a_rx_end_clr: assert property (p_rx_end_clr)
    else $error("receive end flag not cleared");
  a_rx_full_clr: assert property (p_rx_full_clr)
    else $error("receive full flag not cleared");
  a_tx_end_clr: assert property (p_tx_end_clr)
    else $error("transmit end flag not cleared");
  a_tx_empty_clr: assert property (p_tx_empty_clr)
    else $error("transmit empty flag not cleared");
endmodule // pdm_link_properties

/* File: sim/peripheral_dma_channel_tb.sv */
// Testbench joining the channel and the peripheral across their link
`timescale 1ns/1ps
module peripheral_dma_channel_tb;
  localparam logic [31:0] KEY = 32'h5a5a_0000;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        sw_wr_in = 1'b0;
  logic        sw_rd_in = 1'b0;
  logic [8:0]  sw_addr_in = 9'h000;
  logic [31:0] sw_wdata_in = 32'h0000_0000;
  logic [31:0] sw_rdata_out;
  logic        sw_rvalid_out;
  logic        ser_rx_valid_in = 1'b0;
  logic [31:0] ser_rx_data_in = 32'h0000_0000;
  logic        ser_tx_valid_out;
  logic [31:0] ser_tx_data_out;
  logic        mem_req_out, mem_we_out, mem_gnt_in = 1'b0;
  logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in = 32'h0;
  logic [1:0]  mem_size_out;
  logic        irq_out;
  logic [47:0] wq[$];
  int          failures = 0;
  int          comparisons = 0;
  pdm_link_if lnk ();
  pdm_channel u_pdm_channel (.clock_in(clock_in), .srst_in(srst_in),
    .lnk(lnk), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_addr_out(mem_addr_out), .mem_size_out(mem_size_out),
    .mem_wdata_out(mem_wdata_out), .mem_gnt_in(mem_gnt_in),
    .mem_rdata_in(mem_rdata_in));
  pdm_periph u_pdm_periph (.clock_in(clock_in), .srst_in(srst_in),
    .lnk(lnk), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in),
    .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in),
    .sw_rdata_out(sw_rdata_out), .sw_rvalid_out(sw_rvalid_out),
    .ser_rx_valid_in(ser_rx_valid_in), .ser_rx_data_in(ser_rx_data_in),
    .ser_tx_valid_out(ser_tx_valid_out), .ser_tx_data_out(ser_tx_data_out),
    .ser_tx_ready_in(1'b1), .irq_out(irq_out));
  pdm_link_properties u_pdm_link_properties (.clock_in(clock_in),
    .srst_in(srst_in), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_rvalid(lnk.reg_rvalid), .rx_channel_trigger(lnk.rx_channel_trigger),
    .rx_ack(lnk.rx_ack), .tx_channel_trigger(lnk.tx_channel_trigger),
    .tx_wr(lnk.tx_wr), .half_duplex(lnk.half_duplex),
    .rx_end_flag(lnk.rx_end_flag), .tx_end_flag(lnk.tx_end_flag),
    .rx_buffer_full_flag(lnk.rx_buffer_full_flag),
    .tx_buffer_empty_flag(lnk.tx_buffer_empty_flag));
  // ==========================================================================
  // Clock; memory grants one cycle after each request, logs writes
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    mem_gnt_in <= mem_req_out & ~mem_gnt_in;
    mem_rdata_in <= mem_addr_out ^ KEY;
    if (mem_gnt_in && mem_req_out && mem_we_out)
      wq.push_back({mem_addr_out, mem_size_out, mem_wdata_out[13:0]});
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock_in);
    sw_wr_in <= 1'b1; sw_addr_in <= a; sw_wdata_in <= d;
    @(posedge clock_in);
    sw_wr_in <= 1'b0;
  endtask
  // Read waits a bounded time for the answer, then compares it
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    int i;
    @(posedge clock_in);
    sw_rd_in <= 1'b1; sw_addr_in <= a;
    @(posedge clock_in);
    sw_rd_in <= 1'b0;
    for (i = 0; i < 8 && sw_rvalid_out !== 1'b1; i++) @(posedge clock_in);
    if (i == 8) begin failures++; report_and_stop(); end
    chk(48'(sw_rdata_out), 48'(exp));
  endtask
  task automatic t_reset();
    rd(pdm_pkg::OFS_PSTAT, 32'h0000_003e);
    rd(pdm_pkg::OFS_MODE, 32'(pdm_pkg::RST_MODE));
    $display("test reset done");
  endtask
  // Transmit with reload from next pair; words leave in pointer order
  task automatic t_tx();
    int i;
    wr(pdm_pkg::OFS_TX_PTR, 32'h0000_1000);
    wr(pdm_pkg::OFS_TX_CNT, 32'h1);
    wr(pdm_pkg::OFS_TX_NPTR, 32'h0000_2000);
    wr(pdm_pkg::OFS_TX_NCNT, 32'h1);
    wr(pdm_pkg::OFS_CTRL, 32'h0000_0100);
    for (int w = 0; w < 2; w++) begin
      for (i = 0; i < 60 && ser_tx_valid_out !== 1'b1; i++)
        @(posedge clock_in);
      if (i == 60) begin failures++; report_and_stop(); end
      chk(48'(ser_tx_data_out), 48'(KEY ^ (32'h1000 << w)));
      @(posedge clock_in);
    end
    repeat (6) @(posedge clock_in);
    rd(pdm_pkg::OFS_TX_CNT, 32'h0);
    rd(pdm_pkg::OFS_TX_NCNT, 32'h0);
    rd(pdm_pkg::OFS_TX_PTR, 32'h0000_2004);
    rd(pdm_pkg::OFS_STAT, 32'h0000_0100);
    wr(pdm_pkg::OFS_CTRL, 32'h0000_0200);
    rd(pdm_pkg::OFS_STAT, 32'h0);
    $display("test tx done");
  endtask
  // Half-word receive: pointer steps by two, flags set once drained
  task automatic t_rx();
    wr(pdm_pkg::OFS_MODE, 32'h11);
    wr(pdm_pkg::OFS_RX_PTR, 32'h0000_3000);
    wr(pdm_pkg::OFS_RX_CNT, 32'h2);
    wr(pdm_pkg::OFS_CTRL, 32'h0000_0001);
    for (int w = 1; w < 3; w++) begin
      @(posedge clock_in);
      ser_rx_valid_in <= 1'b1; ser_rx_data_in <= 32'(w * 16'h1111);
      @(posedge clock_in);
      ser_rx_valid_in <= 1'b0;
      repeat (10) @(posedge clock_in);
    end
    chk(48'(wq.size()), 48'd2);
    for (int w = 0; w < 2 && w < wq.size(); w++)
      chk(wq[w], {32'h3000 + 32'(2 * w), 2'h1,
                  14'((w + 1) * 16'h1111)});
    rd(pdm_pkg::OFS_RX_PTR, 32'h0000_3004);
    rd(pdm_pkg::OFS_PSTAT, 32'h0000_003e);
    chk(48'(irq_out), 48'h1);
    wr(pdm_pkg::OFS_RX_NCNT, 32'h1);
    rd(pdm_pkg::OFS_PSTAT, 32'h0000_002a);
    rd(pdm_pkg::OFS_RX_CNT, 32'h1);
    chk(48'(irq_out), 48'h0);
    wr(pdm_pkg::OFS_MODE, 32'h5);
    rd(pdm_pkg::OFS_RX_PTR, 32'h0000_2004);
    $display("test rx done");
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    t_reset();
    t_tx();
    t_rx();
    report_and_stop();
  end
endmodule // peripheral_dma_channel_tb

/* File: src/pdm_buf2.sv */
// Small valid/ready buffer holding received items on their way to memory
`timescale 1ns/1ps
module pdm_buf2 #(
  parameter int W     = 66,
  parameter int DEPTH = 2
) (
  input  wire logic         clock_in,
  input  wire logic         srst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } pdm_buf_state_t;

  pdm_buf_state_t q, d;
  logic           push;
  logic           pop;

  // ==========================================================================
  // Handshakes; full and empty come straight from the fill count
  assign in_ready_out  = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = q.mem[q.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Pointer wrap kept explicit so DEPTH need not be a power of two
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_in;
      d.wp = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + PW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + PW'(1);
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // pdm_buf2

/* File: src/pdm_channel.sv */
// DMA channel pair moving serial peripheral data to and from memory
// Function
// - Each direction has current and next pointer/count
// - Four pointers, four counters: tx and rx
// - Half duplex: software programs one direction only
// - Counter reads return remaining transfers
// - Enable/disable bits; enabled state readable
// - Pointer advances by 1, 2, 4 bytes; here item_size 3 advances it by 8
// - Rewritten pointer used for next item
// - Current count decrements per moved item
// - Both counts zero: stop and flag
// - Current zero, next nonzero: reload, clear next
// - Receive end flag: set drained, cleared nonzero write
// - Receive full flag: both zero, cleared rx write
// - Transmit end flag set after last holding write
// - Transmit empty flag: both zero, cleared write
// - Receive trigger: read holding, buffer, write memory
// - Transmit trigger: read memory, fill holding register
// - Peripheral raises end-of-transfer interrupt itself
// - Half duplex uses one set by direction
// - Triggers and flags seen via peripheral status
// - Peripheral control register starts channel activity
// - Zero count halts, nonzero runs when enabled
`timescale 1ns/1ps
module pdm_channel (
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  pdm_link_if.chan        lnk,
  output logic            mem_req_out,
  output logic            mem_we_out,
  output logic [31:0]     mem_addr_out,
  output logic [1:0]      mem_size_out,
  output logic [31:0]     mem_wdata_out,
  input  wire logic       mem_gnt_in,
  input  wire logic [31:0] mem_rdata_in
);
  localparam int BW = pdm_pkg::ADDR_W + pdm_pkg::DATA_W + pdm_pkg::SZ_W;

  typedef enum logic [1:0] {ST_IDLE, ST_RX_WR, ST_TX_RD} pdm_chan_st_t;

  typedef struct packed {
    logic [1:0][31:0] ptr;
    logic [1:0][31:0] nptr;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] ncnt;
    logic [1:0]       en;
    logic [1:0]       end_f;
    logic [1:0]       buf_f;
    logic             rx_ack;
    logic             tx_wr;
    logic [31:0]      tx_data;
    pdm_chan_st_t     st;
    logic             mem_req;
    logic             mem_we;
    logic [31:0]      mem_addr;
    logic [1:0]       mem_size;
    logic [31:0]      mem_wdata;
    logic [31:0]      rdata;
    logic             rvalid;
  } pdm_chan_state_t;

  pdm_chan_state_t q, d;
  logic            rs;
  logic [31:0]     inc;
  logic            rx_go;
  logic            tx_go;
  logic            push;
  logic            pop;
  logic            buf_in_rdy;
  logic            buf_out_vld;
  logic [BW-1:0]   buf_out;
  logic [1:0]      busy;
  logic [1:0]      reload;

  // ==========================================================================
  // Set selection and step size
  // Half duplex drives both directions through the transmit set
  assign rs  = lnk.half_duplex ? 1'(pdm_pkg::CH_TX)
                               : 1'(pdm_pkg::CH_RX);
  assign inc = 32'h0000_0001 << lnk.item_size;

  // Receive take: zero count or a full buffer holds the peripheral off
  assign rx_go = q.en[pdm_pkg::CH_RX] && !(lnk.half_duplex && lnk.dir_tx)
              && (q.cnt[rs] != '0) && lnk.rx_channel_trigger
              && !q.rx_ack && buf_in_rdy;
  assign tx_go = q.en[pdm_pkg::CH_TX] && (!lnk.half_duplex || lnk.dir_tx)
              && (q.cnt[pdm_pkg::CH_TX] != '0) && lnk.tx_channel_trigger
              && !q.tx_wr;
  assign push  = rx_go;
  assign pop   = (q.st == ST_RX_WR) && mem_gnt_in;
  // A set counts as drained once nothing of it is buffered or on the bus
  assign busy[pdm_pkg::CH_RX] = buf_out_vld || (q.st == ST_RX_WR);
  assign busy[pdm_pkg::CH_TX] = (q.st == ST_TX_RD)
                             || (lnk.half_duplex && busy[pdm_pkg::CH_RX]);

  // ==========================================================================
  // Received items wait here, so a slow bus grant loses no word
  pdm_buf2 #(
    .W     (BW),
    .DEPTH (2)
  ) u_rx_buf (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .in_valid_in   (push),
    .in_ready_out  (buf_in_rdy),
    .in_data_in    ({q.ptr[rs], lnk.rx_hold_data, lnk.item_size}),
    .out_valid_out (buf_out_vld),
    .out_ready_in  (pop),
    .out_data_out  (buf_out)
  );

  // ==========================================================================
  // Next state: transfers, register access, reload, flags
  always_comb begin
    d        = q;
    d.rx_ack = 1'b0;
    d.tx_wr  = 1'b0;
    d.rvalid = 1'b0;
    reload   = 2'b00;
    // Receive item taken from the holding register
    if (rx_go) begin
      d.rx_ack  = 1'b1;
      d.ptr[rs] = q.ptr[rs] + inc;
      d.cnt[rs] = q.cnt[rs] - 16'h0001;
    end
    // Bus master sequencer; receive wins to avoid an overrun
    case (q.st)
      ST_IDLE: begin
        if (buf_out_vld) begin
          d.st        = ST_RX_WR;
          d.mem_req   = 1'b1;
          d.mem_we    = 1'b1;
          d.mem_addr  = buf_out[BW-1 -: pdm_pkg::ADDR_W];
          d.mem_wdata = buf_out[pdm_pkg::SZ_W +: pdm_pkg::DATA_W];
          d.mem_size  = buf_out[pdm_pkg::SZ_W-1:0];
        end else if (tx_go) begin
          d.st        = ST_TX_RD;
          d.mem_req   = 1'b1;
          d.mem_we    = 1'b0;
          d.mem_addr  = q.ptr[pdm_pkg::CH_TX];
          d.mem_size  = lnk.item_size;
        end
      end
      ST_RX_WR: begin
        if (mem_gnt_in) begin
          d.st      = ST_IDLE;
          d.mem_req = 1'b0;
        end
      end
      ST_TX_RD: begin
        if (mem_gnt_in) begin
          d.st      = ST_IDLE;
          d.mem_req = 1'b0;
          d.tx_data = mem_rdata_in;
          d.tx_wr   = 1'b1;
          d.ptr[pdm_pkg::CH_TX] = q.ptr[pdm_pkg::CH_TX] + inc;
          d.cnt[pdm_pkg::CH_TX] = q.cnt[pdm_pkg::CH_TX] - 16'h0001;
        end
      end
      default: begin
        d.st      = ST_IDLE;
        d.mem_req = 1'b0;
      end
    endcase
    // Software writes override the hardware update of the same cycle
    if (lnk.reg_wr) begin
      case (lnk.reg_addr)
        pdm_pkg::OFS_RX_PTR:  d.ptr[rs] = lnk.reg_wdata;
        pdm_pkg::OFS_RX_NPTR: d.nptr[rs] = lnk.reg_wdata;
        pdm_pkg::OFS_TX_PTR:  d.ptr[pdm_pkg::CH_TX] = lnk.reg_wdata;
        pdm_pkg::OFS_TX_NPTR: d.nptr[pdm_pkg::CH_TX] = lnk.reg_wdata;
        pdm_pkg::OFS_RX_CNT:  d.cnt[rs] = lnk.reg_wdata[15:0];
        pdm_pkg::OFS_RX_NCNT: d.ncnt[rs] = lnk.reg_wdata[15:0];
        pdm_pkg::OFS_TX_CNT:  d.cnt[pdm_pkg::CH_TX] = lnk.reg_wdata[15:0];
        pdm_pkg::OFS_TX_NCNT: d.ncnt[pdm_pkg::CH_TX] = lnk.reg_wdata[15:0];
        pdm_pkg::OFS_CTRL: begin
          // Disable beats enable when both are written together
          if (lnk.reg_wdata[pdm_pkg::CTRL_RX_EN])
            d.en[pdm_pkg::CH_RX] = 1'b1;
          if (lnk.reg_wdata[pdm_pkg::CTRL_RX_DIS])
            d.en[pdm_pkg::CH_RX] = 1'b0;
          if (lnk.reg_wdata[pdm_pkg::CTRL_TX_EN])
            d.en[pdm_pkg::CH_TX] = 1'b1;
          if (lnk.reg_wdata[pdm_pkg::CTRL_TX_DIS])
            d.en[pdm_pkg::CH_TX] = 1'b0;
        end
        default: ;
      endcase
      // Nonzero count write re-arms both flags of that set
      if (lnk.reg_wdata[15:0] != '0) begin
        if (lnk.reg_addr == pdm_pkg::OFS_RX_CNT
            || lnk.reg_addr == pdm_pkg::OFS_RX_NCNT) begin
          d.end_f[rs] = 1'b0;
          d.buf_f[rs] = 1'b0;
        end
        if (lnk.reg_addr == pdm_pkg::OFS_TX_CNT
            || lnk.reg_addr == pdm_pkg::OFS_TX_NCNT) begin
          d.end_f[pdm_pkg::CH_TX] = 1'b0;
          d.buf_f[pdm_pkg::CH_TX] = 1'b0;
        end
      end
    end
    // Reload and flag setting per set; a reload sets no end flag in a cycle with a link register write
    for (int s = 0; s < 2; s++) begin
      if (d.cnt[s] == '0 && d.ncnt[s] != '0) begin
        reload[s] = 1'b1;
        d.ptr[s]  = d.nptr[s];
        d.cnt[s]  = d.ncnt[s];
        d.nptr[s] = pdm_pkg::RST_PTR;
        d.ncnt[s] = pdm_pkg::RST_CNT;
      end
      if (q.cnt[s] == '0 && d.cnt[s] == '0 && !busy[s]) begin
        d.end_f[s] = 1'b1;
        if (q.ncnt[s] == '0)
          d.buf_f[s] = 1'b1;
      end
      if (reload[s] && !lnk.reg_wr)
        d.end_f[s] = 1'b1;
    end
    // Register read answer, one cycle after the strobe
    if (lnk.reg_rd) begin
      d.rvalid = 1'b1;
      case (lnk.reg_addr)
        pdm_pkg::OFS_RX_PTR:  d.rdata = q.ptr[rs];
        pdm_pkg::OFS_RX_NPTR: d.rdata = q.nptr[rs];
        pdm_pkg::OFS_TX_PTR:  d.rdata = q.ptr[pdm_pkg::CH_TX];
        pdm_pkg::OFS_TX_NPTR: d.rdata = q.nptr[pdm_pkg::CH_TX];
        pdm_pkg::OFS_RX_CNT:  d.rdata = {16'h0000, q.cnt[rs]};
        pdm_pkg::OFS_RX_NCNT: d.rdata = {16'h0000, q.ncnt[rs]};
        pdm_pkg::OFS_TX_CNT:
          d.rdata = {16'h0000, q.cnt[pdm_pkg::CH_TX]};
        pdm_pkg::OFS_TX_NCNT:
          d.rdata = {16'h0000, q.ncnt[pdm_pkg::CH_TX]};
        pdm_pkg::OFS_STAT: begin
          d.rdata = 32'h0000_0000;
          d.rdata[pdm_pkg::STAT_RX_ON] = q.en[pdm_pkg::CH_RX];
          d.rdata[pdm_pkg::STAT_TX_ON] = q.en[pdm_pkg::CH_TX];
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs straight from state; flags go back to the peripheral
  assign lnk.reg_rdata            = q.rdata;
  assign lnk.reg_rvalid           = q.rvalid;
  assign lnk.rx_ack               = q.rx_ack;
  assign lnk.tx_hold_data         = q.tx_data;
  assign lnk.tx_wr                = q.tx_wr;
  assign lnk.rx_end_flag          = q.end_f[rs];
  assign lnk.rx_buffer_full_flag  = q.buf_f[rs];
  assign lnk.tx_end_flag          = q.end_f[pdm_pkg::CH_TX];
  assign lnk.tx_buffer_empty_flag = q.buf_f[pdm_pkg::CH_TX];
  assign mem_req_out              = q.mem_req;
  assign mem_we_out               = q.mem_we;
  assign mem_addr_out             = q.mem_addr;
  assign mem_size_out             = q.mem_size;
  assign mem_wdata_out            = q.mem_wdata;
endmodule // pdm_channel

/* File: src/pdm_link_if.sv */
// Link between the DMA channel and the serial peripheral it serves
`timescale 1ns/1ps
interface pdm_link_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [8:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic        rx_channel_trigger;
  logic [31:0] rx_hold_data;
  logic        rx_ack;
  logic        tx_channel_trigger;
  logic [31:0] tx_hold_data;
  logic        tx_wr;
  logic [1:0]  item_size;
  logic        half_duplex;
  logic        dir_tx;
  logic        rx_end_flag;
  logic        tx_end_flag;
  logic        rx_buffer_full_flag;
  logic        tx_buffer_empty_flag;

  modport chan (
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid,
    input  rx_channel_trigger, rx_hold_data,
    output rx_ack,
    input  tx_channel_trigger,
    output tx_hold_data, tx_wr,
    input  item_size, half_duplex, dir_tx,
    output rx_end_flag, tx_end_flag, rx_buffer_full_flag,
    output tx_buffer_empty_flag
  );

  modport periph (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata, reg_rvalid,
    output rx_channel_trigger, rx_hold_data,
    input  rx_ack,
    output tx_channel_trigger,
    input  tx_hold_data, tx_wr,
    output item_size, half_duplex, dir_tx,
    input  rx_end_flag, tx_end_flag, rx_buffer_full_flag,
    input  tx_buffer_empty_flag
  );
endinterface

/* File: src/pdm_periph.sv */
// Serial peripheral end: holding registers, status, register forwarding
`timescale 1ns/1ps
module pdm_periph (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  pdm_link_if.periph       lnk,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  input  wire logic [8:0]  sw_addr_in,
  input  wire logic [31:0] sw_wdata_in,
  output logic [31:0]      sw_rdata_out,
  output logic             sw_rvalid_out,
  input  wire logic        ser_rx_valid_in,
  input  wire logic [31:0] ser_rx_data_in,
  output logic             ser_tx_valid_out,
  output logic [31:0]      ser_tx_data_out,
  input  wire logic        ser_tx_ready_in,
  output logic             irq_out
);
  typedef struct packed {
    logic [31:0] rx_holding_register;
    logic        rhr_full;
    logic [31:0] tx_holding_register;
    logic        thr_empty;
    logic [5:0]  mode;
    logic        tx_valid;
    logic [31:0] tx_data;
    logic        l_wr;
    logic        l_rd;
    logic [8:0]  l_addr;
    logic [31:0] l_wdata;
    logic [31:0] rdata;
    logic        rvalid;
    logic        irq;
  } pdm_per_state_t;

  pdm_per_state_t q, d;
  logic           fwd;

  // Offsets at and above the channel block belong to the DMA channel
  assign fwd = (sw_addr_in >= pdm_pkg::OFS_RX_PTR);

  // ==========================================================================
  // Holding registers, serial side, register traffic
  always_comb begin
    d        = q;
    d.l_wr   = sw_wr_in && fwd;
    d.l_rd   = sw_rd_in && fwd;
    d.l_addr = sw_addr_in;
    d.l_wdata = sw_wdata_in;
    d.rvalid = 1'b0;
    // New arrival beats the channel's acknowledge; overrun overwrites
    if (lnk.rx_ack)
      d.rhr_full = 1'b0;
    if (ser_rx_valid_in) begin
      d.rx_holding_register      = ser_rx_data_in;
      d.rhr_full = 1'b1;
    end
    // Transmit holding register drains into the serial output stage
    if (ser_tx_ready_in)
      d.tx_valid = 1'b0;
    if (!q.thr_empty && (!q.tx_valid || ser_tx_ready_in)) begin
      d.tx_valid  = 1'b1;
      d.tx_data   = q.tx_holding_register;
      d.thr_empty = 1'b1;
    end
    if (lnk.tx_wr) begin
      d.tx_holding_register       = lnk.tx_hold_data;
      d.thr_empty = 1'b0;
    end
    // Mode: item size and, for half duplex, the one live direction
    if (sw_wr_in && sw_addr_in == pdm_pkg::OFS_MODE)
      d.mode = sw_wdata_in[pdm_pkg::MODE_W-1:0];
    // Read answers: own registers now, channel ones when returned
    if (sw_rd_in && !fwd) begin
      d.rvalid = 1'b1;
      d.rdata  = 32'h0000_0000;
      if (sw_addr_in == pdm_pkg::OFS_MODE)
        d.rdata[pdm_pkg::MODE_W-1:0] = q.mode;
      if (sw_addr_in == pdm_pkg::OFS_PSTAT) begin
        d.rdata[pdm_pkg::PST_RX_TRIG] = q.rhr_full;
        d.rdata[pdm_pkg::PST_TX_TRIG] = q.thr_empty;
        d.rdata[pdm_pkg::PST_RX_END]  = lnk.rx_end_flag;
        d.rdata[pdm_pkg::PST_TX_END]  = lnk.tx_end_flag;
        d.rdata[pdm_pkg::PST_RX_FULL] = lnk.rx_buffer_full_flag;
        d.rdata[pdm_pkg::PST_TX_EMPT] = lnk.tx_buffer_empty_flag;
      end
    end
    if (lnk.reg_rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = lnk.reg_rdata;
    end
    // End-of-transfer interrupt is the peripheral's own
    d.irq = (q.mode[pdm_pkg::MODE_IRQ_RX] && lnk.rx_buffer_full_flag)
         || (q.mode[pdm_pkg::MODE_IRQ_TX] && lnk.tx_buffer_empty_flag);
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      q           <= '0;
      q.thr_empty <= 1'b1;
      q.mode      <= pdm_pkg::RST_MODE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs from state
  assign lnk.reg_wr             = q.l_wr;
  assign lnk.reg_rd             = q.l_rd;
  assign lnk.reg_addr           = q.l_addr;
  assign lnk.reg_wdata          = q.l_wdata;
  assign lnk.rx_channel_trigger = q.rhr_full;
  assign lnk.rx_hold_data       = q.rx_holding_register;
  assign lnk.tx_channel_trigger = q.thr_empty;
  assign lnk.item_size   = q.mode[pdm_pkg::MODE_SIZE +: pdm_pkg::SZ_W];
  assign lnk.half_duplex = q.mode[pdm_pkg::MODE_HALF];
  assign lnk.dir_tx      = q.mode[pdm_pkg::MODE_DIR_TX];
  assign sw_rdata_out     = q.rdata;
  assign sw_rvalid_out    = q.rvalid;
  assign ser_tx_valid_out = q.tx_valid;
  assign ser_tx_data_out  = q.tx_data;
  assign irq_out          = q.irq;
endmodule // pdm_periph

/* File: src/pdm_pkg.sv */
// Shared constants for the peripheral DMA channel and its serial peripheral
package pdm_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int OFS_W  = 9;
  localparam int SZ_W   = 2;

  // ==========================================================================
  // Channel register offsets (byte addresses inside the peripheral)
  localparam logic [8:0] OFS_RX_PTR  = 9'h100;
  localparam logic [8:0] OFS_RX_CNT  = 9'h104;
  localparam logic [8:0] OFS_TX_PTR  = 9'h108;
  localparam logic [8:0] OFS_TX_CNT  = 9'h10c;
  localparam logic [8:0] OFS_RX_NPTR = 9'h110;
  localparam logic [8:0] OFS_RX_NCNT = 9'h114;
  localparam logic [8:0] OFS_TX_NPTR = 9'h118;
  localparam logic [8:0] OFS_TX_NCNT = 9'h11c;
  localparam logic [8:0] OFS_CTRL    = 9'h120;
  localparam logic [8:0] OFS_STAT    = 9'h124;
  // Peripheral's own registers
  localparam logic [8:0] OFS_MODE    = 9'h004;
  localparam logic [8:0] OFS_PSTAT   = 9'h014;

  // ==========================================================================
  // Field positions
  localparam int CTRL_RX_EN  = 0;
  localparam int CTRL_RX_DIS = 1;
  localparam int CTRL_TX_EN  = 8;
  localparam int CTRL_TX_DIS = 9;
  localparam int STAT_RX_ON  = 0;
  localparam int STAT_TX_ON  = 8;
  localparam int MODE_SIZE   = 0;
  localparam int MODE_HALF   = 2;
  localparam int MODE_DIR_TX = 3;
  localparam int MODE_IRQ_RX = 4;
  localparam int MODE_IRQ_TX = 5;
  localparam int MODE_W      = 6;
  localparam int PST_RX_TRIG = 0;
  localparam int PST_TX_TRIG = 1;
  localparam int PST_RX_END  = 2;
  localparam int PST_TX_END  = 3;
  localparam int PST_RX_FULL = 4;
  localparam int PST_TX_EMPT = 5;

  // ==========================================================================
  // Channel sets and reset values
  localparam int CH_RX = 0;
  localparam int CH_TX = 1;
  localparam logic [31:0] RST_PTR  = 32'h0000_0000;
  localparam logic [15:0] RST_CNT  = 16'h0000;
  localparam logic [5:0]  RST_MODE = 6'h02;

endpackage
